// >>> testbench/timer_pair_combination_modes_tb_top.sv
// self-checking bench for the timer pair combination block
// assumes the design files and the pin model compiled first
`timescale 1ns/1ns
`default_nettype none
module timer_pair_combination_modes_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, c3_in, ext_clk, t3_pin, ser_out;
  logic run = 1'b0;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int g;
  always #5 clock = ~clock;
  tpcm_top tpcm_top_inst (.CLOCK(clock), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .COUNTER3_EXT_INPUT(c3_in), .EXT_CLOCK_PIN(ext_clk),
    .TIMER3_OUTPUT_PIN(t3_pin), .SERIAL_DATA_OUT(ser_out));
  tpcm_pin_model tpcm_pin_model_inst (.clock(clock), .run(run),
    .counter3_ext_input(c3_in), .ext_clock_pin(ext_clk));
  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  // period between two timer pin toggles, 0 when none
  task automatic gap(output int res);
    int n;
    logic p;
    n = 0;
    @(posedge clock);
    p = t3_pin;
    while (t3_pin === p && n < 60) begin
      @(posedge clock);
      n++;
    end
    res = 0;
    if (n < 60) begin
      p = t3_pin;
      n = 0;
      while (t3_pin === p && n < 60) begin
        @(posedge clock);
        n++;
      end
      res = n;
    end
  endtask
  // gated event count with capture and rearm
  task automatic test_gate;
    wb(1'b1, 4'h2, 32'h0000_00FF);
    wb(1'b1, 4'h3, 32'h0000_00FF);
    wb(1'b1, 4'h1, 32'h0000_0063);
    wb(1'b1, 4'h0, 32'h31B0_50FF);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h31B0_5000);
    run <= 1'b1;
    repeat (350) @(posedge clock);
    wb(1'b0, 4'h5, 32'h0);
    chk(rd, 32'h0000_000A);
    wb(1'b0, 4'h6, 32'h0);
    chk(rd & 32'h70, 32'h70);
    run <= 1'b0;
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
  endtask
  // bursts gated by shift data and by the idle timer two flop
  task automatic test_burst;
    // fresh reset so counters and flops start from known values
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    wb(1'b1, 4'h2, 32'h0000_0001);
    wb(1'b1, 4'h3, 32'h0000_00FF);
    wb(1'b1, 4'h4, 32'h0000_00FF);
    wb(1'b1, 4'h0, 32'h7080_5000);
    chk({31'h0, ser_out}, 32'h1);
    gap(g);
    chk(32'(g), 32'h2);
    wb(1'b1, 4'h4, 32'h0000_0000);
    chk({31'h0, ser_out}, 32'h0);
    gap(g);
    chk(32'(g), 32'h0);
    chk({31'h0, t3_pin}, 32'h0);
    wb(1'b1, 4'h4, 32'h0000_00FF);
    wb(1'b1, 4'h0, 32'h6080_5000);
    gap(g);
    chk(32'(g), 32'h0);
    chk({31'h0, t3_pin}, 32'h0);
    // run timer two for exactly one match so its flop goes high
    wb(1'b1, 4'h1, 32'h0000_0001);
    wb(1'b1, 4'h0, 32'h6180_5000);
    wb(1'b1, 4'h0, 32'h6080_5000);
    gap(g);
    chk(32'(g), 32'h2);
  endtask
  // interval picked by shift data
  task automatic test_fsk;
    wb(1'b1, 4'h2, 32'h0000_0003);
    wb(1'b1, 4'h3, 32'h0000_0009);
    wb(1'b1, 4'h4, 32'h0000_0000);
    wb(1'b1, 4'h0, 32'h8080_5000);
    gap(g);
    chk(32'(g), 32'h4);
    wb(1'b1, 4'h4, 32'h0000_00FF);
    gap(g);
    chk(32'(g), 32'hA);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    test_gate();
    test_burst();
    test_fsk();
    print_verdict();
  end
endmodule
bind tpcm_top tpcm_sva tpcm_sva_inst (.CLOCK(CLOCK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .TIMER3_OUTPUT_PIN(TIMER3_OUTPUT_PIN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT));
`default_nettype wire

// >>> testbench/tpcm_pin_model.sv
// far side pins: event source on the counter input, idle shift clock
// assumes the bench clock; changes pins just after rising edges
`timescale 1ns/1ns
`default_nettype none
module tpcm_pin_model (
  // clock and control
  input wire logic clock,
  input wire logic run,
  // pins
  output logic counter3_ext_input,
  output logic ext_clock_pin
);
  int phase;
  initial begin
    phase = 0;
    counter3_ext_input = 1'b0;
    ext_clock_pin = 1'b0;
  end
  // one rising edge every ten clocks while running
  always @(posedge clock) begin
    phase <= (phase == 9) ? 0 : phase + 1;
    counter3_ext_input <= run && (phase < 5);
    ext_clock_pin <= 1'b0; // no shift clock, data held
  end
endmodule
`default_nettype wire

// >>> testbench/tpcm_top_sva.sv
// bus and pin assertions for the timer pair combination block
// assumes a bind onto tpcm_top in the bench top file
`timescale 1ns/1ns
`default_nettype none
module tpcm_sva (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // wishbone
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // pins
  input wire logic TIMER3_OUTPUT_PIN,
  input wire logic SERIAL_DATA_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // request seen while no answer pending
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_once;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  property p_ack_next; s_take |=> s_ack_once; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_idle_quiet; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("ack after idle");
  property p_dat_zero; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("data outside ack");
  property p_rst_t3; $rose(RST_B) |-> !TIMER3_OUTPUT_PIN; endproperty
  a_rst_t3: assert property (p_rst_t3) else $error("timer pin set in reset");
  property p_rst_ser; $rose(RST_B) |-> !SERIAL_DATA_OUT; endproperty
  a_rst_ser: assert property (p_rst_ser) else $error("serial out set in reset");
  property p_rst_bus; $rose(RST_B) |-> !WB_ACK_O && WB_DAT_O == 32'h0; endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus active in reset");
endmodule
`default_nettype wire

// >>> verilog/tpcm_params.svh
// constants for the timer pair combination block
// assumes inclusion by bare name from the package and the design file
`ifndef TPCM_PARAMS_SVH
`define TPCM_PARAMS_SVH
`define TPCM_ADR_CTRL 4'h0
`define TPCM_ADR_T2CMP 4'h1
`define TPCM_ADR_T3CMP1 4'h2
`define TPCM_ADR_T3CMP2 4'h3
`define TPCM_ADR_SHIFT 4'h4
`define TPCM_ADR_CAPT 4'h5
`define TPCM_ADR_STAT 4'h6
`define TPCM_ADR_COUNT 4'h7
`define TPCM_T3_MODE_CAPT 4'h3
`define TPCM_T3_MODE_BURST2 4'h6
`define TPCM_T3_MODE_BURSTS 4'h7
`define TPCM_T3_MODE_FSK 4'h8
`define TPCM_SRC_DIV 2'h0
`define TPCM_SRC_EXT 2'h1
`define TPCM_SRC_TOG 2'h2
`define TPCM_SRC_PRE 2'h3
`define TPCM_SER_MODE_SHIFT 2'h1
`define TPCM_SHIFT_BITS 8
`define TPCM_PRE_BITS 4
`define TPCM_T2_BITS 12
`define TPCM_T3_BITS 8
`define TPCM_CTRL_RST 32'h0000_0000
`endif

// >>> verilog/tpcm_pkg.sv
// types for the timer pair combination block
// assumes the params header on the include path
`include "tpcm_params.svh"
package tpcm_pkg;
  // control register layout, high bits first as packed fields go
  typedef struct packed {
    logic [3:0] t3_mode;
    logic [1:0] rsv;
    logic ser_load;
    logic t2_run;
    logic t3_run;
    logic t2_eight;
    logic [1:0] single_en;
    logic [1:0] t3_src;
    logic [1:0] t2_src;
    logic [1:0] ser_src;
    logic [1:0] ser_mode;
    logic [3:0] pre_div;
    logic [7:0] pad;
  } tpcm_ctrl_s;
  // bus request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } tpcm_req_s;
endpackage

// >>> verilog/tpcm_top.sv
// two timers and a shift unit joined for gate, burst and fsk modes
// assumes classic wishbone master on CLOCK and external pins async to it
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tpcm_params.svh"
module tpcm_top #(
  parameter int SHIFT_BITS = `TPCM_SHIFT_BITS
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [5:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // pins
  input wire logic COUNTER3_EXT_INPUT,
  input wire logic EXT_CLOCK_PIN,
  output logic TIMER3_OUTPUT_PIN,
  output logic SERIAL_DATA_OUT
);
  // pin synchronisers
  logic [1:0] sync_t3i;
  logic [1:0] sync_eck;
  logic last_t3i;
  logic last_eck;
  tpcm_pkg::tpcm_ctrl_s ctrl;
  tpcm_pkg::tpcm_ctrl_s next_ctrl;
  logic [11:0] t2_cmp, next_t2_cmp;
  logic [7:0] t3_cmp1, next_t3_cmp1;
  logic [7:0] t3_cmp2, next_t3_cmp2;
  logic [SHIFT_BITS-1:0] shreg, next_shreg;
  logic [7:0] capt, next_capt;
  logic [7:0] cnt3, next_cnt3;
  logic [11:0] cnt2, next_cnt2;
  logic [3:0] pre, next_pre;
  logic [3:0] div, next_div;
  logic timer2_toggle_pulse, next_timer2_toggle_pulse;
  logic timer3_toggle_pulse, next_timer3_toggle_pulse;
  logic m2, next_m2;
  logic m3, next_m3;
  logic prescaler_match_pulse, next_prescaler_match_pulse;
  logic [1:0] armed, next_armed;
  logic trig_seen, next_trig_seen;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic t3_pin, next_t3_pin;
  logic so_pin, next_so_pin;
  logic ext_edge, eck_edge, div_tick;
  logic wr;
  logic [3:0] widx;

  // source select shared by the three clocked stages
  function automatic logic pick(input logic [1:0] s, input logic d, input logic e,
                                input logic t, input logic p);
    unique case (s)
      `TPCM_SRC_DIV: pick = d;
      `TPCM_SRC_EXT: pick = e;
      `TPCM_SRC_TOG: pick = t;
      `TPCM_SRC_PRE: pick = p;
    endcase
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // two flops before any logic reads a pin
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      sync_t3i <= 2'h0;
      sync_eck <= 2'h0;
      last_t3i <= 1'b0;
      last_eck <= 1'b0;
    end else begin
      sync_t3i <= {sync_t3i[0], COUNTER3_EXT_INPUT};
      sync_eck <= {sync_eck[0], EXT_CLOCK_PIN};
      last_t3i <= sync_t3i[1];
      last_eck <= sync_eck[1];
    end
  end

  // rising edges of synchronised pins and internal divider tick
  always_comb begin
    ext_edge = sync_t3i[1] & ~last_t3i;
    eck_edge = sync_eck[1] & ~last_eck;
    div_tick = (div == 4'h0);
    wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack;
    widx = WB_ADR_I[5:2];
  end

  // bus slave, one wait state, answers every address
  always_comb begin
    logic [31:0] q;
    q = 32'h0000_0000;
    next_ack = WB_CYC_I & WB_STB_I & ~ack;
    next_ctrl = ctrl;
    next_t2_cmp = t2_cmp;
    next_t3_cmp1 = t3_cmp1;
    next_t3_cmp2 = t3_cmp2;
    if (wr) begin
      unique case (widx)
        `TPCM_ADR_CTRL: next_ctrl = tpcm_pkg::tpcm_ctrl_s'(merge(32'(ctrl), WB_DAT_I,
                                    WB_SEL_I));
        `TPCM_ADR_T2CMP: next_t2_cmp = 12'(merge({20'h0, t2_cmp}, WB_DAT_I, WB_SEL_I));
        `TPCM_ADR_T3CMP1: next_t3_cmp1 = 8'(merge({24'h0, t3_cmp1}, WB_DAT_I, WB_SEL_I));
        `TPCM_ADR_T3CMP2: next_t3_cmp2 = 8'(merge({24'h0, t3_cmp2}, WB_DAT_I, WB_SEL_I));
        default: ;
      endcase
    end
    unique case (widx)
      `TPCM_ADR_CTRL: q = 32'(ctrl);
      `TPCM_ADR_T2CMP: q = {20'h0, t2_cmp};
      `TPCM_ADR_T3CMP1: q = {24'h0, t3_cmp1};
      `TPCM_ADR_T3CMP2: q = {24'h0, t3_cmp2};
      `TPCM_ADR_SHIFT: q = 32'(shreg);
      `TPCM_ADR_CAPT: q = {24'h0, capt};
      `TPCM_ADR_STAT: q = {25'h0, trig_seen, armed, m3, m2, timer3_toggle_pulse, timer2_toggle_pulse};
      `TPCM_ADR_COUNT: q = {12'h0, cnt2, cnt3};
      default: q = 32'h0000_0000;
    endcase
    next_rdat = next_ack ? q : 32'h0000_0000;
    next_ctrl.ser_load = 1'b0;
    next_ctrl.pad = 8'h00;
    next_ctrl.rsv = 2'h0;
  end

  // timer two: 12-bit, or 8-bit behind the 4-bit prescaler
  always_comb begin
    logic clk2;
    logic hit;
    hit = 1'b0;
    clk2 = pick(ctrl.t2_src, div_tick, eck_edge, timer3_toggle_pulse, 1'b0);
    next_div = (div == ctrl.pre_div) ? 4'h0 : 4'(div + 4'h1);
    next_cnt2 = cnt2;
    next_pre = pre;
    next_timer2_toggle_pulse = 1'b0;
    next_prescaler_match_pulse = 1'b0;
    next_m2 = m2;
    if (ctrl.t2_run && clk2) begin
      if (ctrl.t2_eight) begin
        if (pre == ctrl.pre_div) begin
          next_pre = 4'h0;
          next_prescaler_match_pulse = 1'b1;
          hit = (cnt2[7:0] == t2_cmp[7:0]);
          next_cnt2 = hit ? 12'h000 : {4'h0, 8'(cnt2[7:0] + 8'h01)};
        end else begin
          next_pre = 4'(pre + 4'h1);
        end
      end else begin
        hit = (cnt2 == t2_cmp);
        next_cnt2 = hit ? 12'h000 : 12'(cnt2 + 12'h001);
      end
    end
    if (hit) begin
      next_timer2_toggle_pulse = 1'b1;
      next_m2 = ~m2;
    end
  end

  // timer three: capture, burst and fsk modes
  always_comb begin
    logic clk3;
    logic trig;
    logic [7:0] cmp;
    logic fsk;
    clk3 = 1'b0;
    trig = 1'b0;
    cmp = 8'h00;
    fsk = (ctrl.t3_mode == `TPCM_T3_MODE_FSK);
    // capture mode forces the counter input pin as clock
    if (ctrl.t3_mode == `TPCM_T3_MODE_CAPT) begin
      clk3 = ext_edge;
    end else begin
      clk3 = pick(ctrl.t3_src, div_tick, ext_edge, 1'b0, eck_edge);
    end
    trig = timer2_toggle_pulse && (ctrl.t3_mode == `TPCM_T3_MODE_CAPT);
    cmp = (fsk && shreg[SHIFT_BITS-1]) ? t3_cmp2 : t3_cmp1;
    next_cnt3 = cnt3;
    next_capt = capt;
    next_timer3_toggle_pulse = 1'b0;
    next_m3 = m3;
    next_armed = armed;
    next_trig_seen = trig_seen | trig;
    if (wr && widx == `TPCM_ADR_STAT) begin
      next_trig_seen = trig;
    end
    if (trig) begin
      // count taken through this edge, so no pin edge is dropped
      next_capt = clk3 ? 8'(cnt3 + 8'h01) : cnt3;
      next_cnt3 = 8'h00;
      next_armed = ctrl.single_en;
    end else if (ctrl.t3_run && clk3) begin
      if (cnt3 == cmp) begin
        next_cnt3 = 8'h00;
        if (!ctrl.single_en[0] || armed[0] || fsk) begin
          next_timer3_toggle_pulse = 1'b1;
          next_m3 = ~m3;
          if (!fsk) begin
            next_armed[0] = 1'b0;
          end
        end
      end else if (!fsk && cnt3 == t3_cmp2 && (!ctrl.single_en[1] || armed[1])) begin
        next_m3 = ~m3;
        next_armed[1] = 1'b0;
        next_cnt3 = 8'(cnt3 + 8'h01);
      end else begin
        next_cnt3 = 8'(cnt3 + 8'h01);
      end
    end
    // output gating per mode
    unique case (ctrl.t3_mode)
      `TPCM_T3_MODE_BURST2: next_t3_pin = m3 & m2;
      `TPCM_T3_MODE_BURSTS: next_t3_pin = m3 & shreg[SHIFT_BITS-1];
      default: next_t3_pin = m3;
    endcase
  end

  // shift unit: msb first, loaded from the bus
  always_comb begin
    logic sclk;
    sclk = pick(ctrl.ser_src, div_tick, eck_edge, timer2_toggle_pulse, prescaler_match_pulse);
    next_shreg = shreg;
    if (wr && widx == `TPCM_ADR_SHIFT) begin
      next_shreg = SHIFT_BITS'(WB_DAT_I);
    end else if (ctrl.ser_mode == `TPCM_SER_MODE_SHIFT && sclk) begin
      next_shreg = {shreg[SHIFT_BITS-2:0], 1'b0};
    end
    next_so_pin = shreg[SHIFT_BITS-1];
  end

  // bus slave registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ctrl <= tpcm_pkg::tpcm_ctrl_s'(`TPCM_CTRL_RST);
      t2_cmp <= 12'h000;
      t3_cmp1 <= 8'h00;
      t3_cmp2 <= 8'h00;
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      t2_cmp <= next_t2_cmp;
      t3_cmp1 <= next_t3_cmp1;
      t3_cmp2 <= next_t3_cmp2;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // timer two registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      cnt2 <= 12'h000;
      pre <= 4'h0;
      div <= 4'h0;
      timer2_toggle_pulse <= 1'b0;
      m2 <= 1'b0;
      prescaler_match_pulse <= 1'b0;
    end else begin
      cnt2 <= next_cnt2;
      pre <= next_pre;
      div <= next_div;
      timer2_toggle_pulse <= next_timer2_toggle_pulse;
      m2 <= next_m2;
      prescaler_match_pulse <= next_prescaler_match_pulse;
    end
  end

  // timer three registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      capt <= 8'h00;
      cnt3 <= 8'h00;
      timer3_toggle_pulse <= 1'b0;
      m3 <= 1'b0;
      armed <= 2'h0;
      trig_seen <= 1'b0;
      t3_pin <= 1'b0;
    end else begin
      capt <= next_capt;
      cnt3 <= next_cnt3;
      timer3_toggle_pulse <= next_timer3_toggle_pulse;
      m3 <= next_m3;
      armed <= next_armed;
      trig_seen <= next_trig_seen;
      t3_pin <= next_t3_pin;
    end
  end

  // shift unit registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      shreg <= '0;
      so_pin <= 1'b0;
    end else begin
      shreg <= next_shreg;
      so_pin <= next_so_pin;
    end
  end

  // outputs straight from flops
  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdat;
  assign TIMER3_OUTPUT_PIN = t3_pin;
  assign SERIAL_DATA_OUT = so_pin;
endmodule
`default_nettype wire
